// [logic/cpu_core.sv]
`include "cpu_cfg.svh"
module cpu_core (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_b_i,
  input  wire logic [15:0]         imem_data_i,
  input  wire logic [3:0]          release_i,
  input  wire cpu_pkg::axi_req_s   axi_req_i,
  output logic [`PC_W-1:0]         imem_addr_o,
  output cpu_pkg::axi_rsp_s        axi_rsp_o
);
  import cpu_pkg::*;

  core_s       s;
  core_s       n;
  logic [3:0]  dmem [0:127];
  instr_s      ins;
  logic [6:0]  m_addr;
  logic [6:0]  r_addr;
  logic [3:0]  m_val;
  logic [3:0]  r_val;
  logic [4:0]  sum5;
  logic [4:0]  dif5;
  logic [4:0]  cmp5;
  logic [`PC_W-1:0] pc_inc;
  logic [`PC_W-1:0] target;
  logic [`SP_W-1:0] sp_dec;
  logic        exec;
  logic        mem_we;
  logic [6:0]  mem_wa;
  logic [3:0]  mem_wd;

  // ==========================================================================
  // decoding helpers
  function automatic logic carry_in_used(input logic [4:0] op);
    carry_in_used = (op[3:0] == 4'h2) || (op[3:0] == 4'h3);
  endfunction : carry_in_used

  function automatic logic [31:0] status_word(input core_s c);
    status_word = 32'h0000_0000;
    status_word[`STAT_PC_LSB +: `PC_W] = c.pc;
    status_word[`STAT_CY_BIT]          = c.carry_flag;
    status_word[`STAT_CMP_BIT]         = c.compare_flag;
    status_word[`STAT_SKIP_BIT]        = c.skip;
    status_word[`STAT_ST_LSB +: 3]     = c.state;
    status_word[`STAT_SP_LSB +: `SP_W] = c.sp;
  endfunction : status_word

  assign ins    = instr_s'(imem_data_i);
  assign m_addr = {ins.row, ins.col};
  assign r_addr = {s.register_pointer, ins.arg};
  assign m_val  = dmem[m_addr];
  assign r_val  = dmem[r_addr];
  assign pc_inc = s.pc + `PC_W'(1);
  assign target = {ins.row, ins.col, ins.arg};
  assign sp_dec = s.sp - `SP_W'(1);
  assign exec   = (s.state == ST_RUN) && s.run_en && !s.skip;

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic [3:0] opa;
    logic [3:0] opb;
    logic       cin;
    opa    = ins.op[4] ? m_val : r_val;
    opb    = ins.op[4] ? ins.arg : m_val;
    cin    = carry_in_used(ins.op) ? s.carry_flag : 1'b0;
    sum5   = {1'b0, opa} + {1'b0, opb} + {4'h0, cin};
    dif5   = {1'b0, opa} - {1'b0, opb} - {4'h0, cin};
    cmp5   = {1'b0, m_val} - {1'b0, ins.arg};
    n      = s;
    mem_we = 1'b0;
    mem_wa = ins.op[4] ? m_addr : r_addr;
    mem_wd = 4'h0;

    // release pins: first stage feeds only the second
    n.sync_a = release_i;
    n.sync_b = s.sync_a;
    n.sync_c = s.sync_b;
    if (s.sync_b == s.sync_c) begin
      n.rel_level = s.sync_c;
    end

    case (s.state)
      ST_HALT, ST_STOP: begin
        // both modes resume at the word after the halting one
        if ((s.rel_level & s.rel_cond) != 4'h0) begin
          n.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (s.run_en) begin
          n.pc   = pc_inc;
          n.skip = 1'b0;
          if (!s.skip) begin
            case (ins.op)
              OP_ADD_RM, OP_ADD_WITH_CARRY_OP_RM, OP_ADD_MI, OP_ADD_WITH_CARRY_OP_MI: begin
                mem_we       = 1'b1;
                mem_wd       = sum5[3:0];
                n.carry_flag = sum5[4];
              end
              OP_SUB_RM, OP_SUB_WITH_BORROW_OP_RM, OP_SUB_MI, OP_SUB_WITH_BORROW_OP_MI: begin
                mem_we       = 1'b1;
                mem_wd       = dif5[3:0];
                n.carry_flag = dif5[4];
              end
              OP_AND_RM, OP_AND_MI: begin
                mem_we = 1'b1;
                mem_wd = opa & opb;
              end
              OP_OR_RM, OP_OR_MI: begin
                mem_we = 1'b1;
                mem_wd = opa | opb;
              end
              OP_XOR_RM, OP_XOR_MI: begin
                mem_we = 1'b1;
                mem_wd = opa ^ opb;
              end
              OP_LOAD: begin
                mem_we = 1'b1;
                mem_wa = r_addr;
                mem_wd = m_val;
              end
              OP_STORE: begin
                mem_we = 1'b1;
                mem_wa = m_addr;
                mem_wd = r_val;
              end
              OP_MOVI: begin
                mem_we = 1'b1;
                mem_wa = m_addr;
                mem_wd = ins.arg;
              end
              OP_SKE:  n.skip = (cmp5[3:0] == 4'h0);
              OP_SKIP_IF_GE_OP: n.skip = !cmp5[4];
              OP_SKIP_IF_LT_OP: n.skip = cmp5[4];
              OP_SKIP_IF_NOT_EQUAL_OP: n.skip = (cmp5[3:0] != 4'h0);
              OP_SKT: begin
                n.compare_flag = 1'b0;
                n.skip         = ((m_val & ins.arg) == ins.arg);
              end
              OP_SKF: begin
                n.compare_flag = 1'b0;
                n.skip         = ((m_val & ins.arg) == 4'h0);
              end
              OP_BRANCH: n.pc = target;
              OP_CALL: begin
                n.sp            = sp_dec;
                n.stack[sp_dec] = pc_inc;
                n.pc            = target;
              end
              OP_GROUP7: begin
                case (ins.row)
                  SUB_RET, SUB_RETURN_AND_SKIP_OP: begin
                    if (ins.col == 4'hE && ins.arg == 4'h0) begin
                      n.pc   = s.stack[s.sp];
                      n.sp   = s.sp + `SP_W'(1);
                      n.skip = (ins.row == SUB_RETURN_AND_SKIP_OP);
                    end else if (ins.row == SUB_RET && ins.col == 4'h7) begin
                      mem_we       = 1'b1;
                      mem_wa       = r_addr;
                      mem_wd       = {s.carry_flag, r_val[3:1]};
                      n.carry_flag = r_val[0];
                    end
                  end
                  SUB_STOP, SUB_HALT: begin
                    if (ins.col == 4'hF) begin
                      n.state    = (ins.row == SUB_HALT) ? ST_HALT : ST_STOP;
                      n.rel_cond = ins.arg;
                    end
                  end
                  default: ;
                endcase
              end
              default: ;
            endcase
          end
        end
      end
      default: n.state = ST_RUN;
    endcase

    // ========================================================================
    // control bus slave: address and data may arrive in either order
    if (axi_req_i.awvalid && s.rsp.awready) begin
      n.aw_hold     = 1'b1;
      n.aw_addr     = axi_req_i.awaddr;
      n.rsp.awready = 1'b0;
    end
    if (axi_req_i.wvalid && s.rsp.wready) begin
      n.w_hold     = 1'b1;
      n.w_data     = axi_req_i.wdata;
      n.w_strb     = axi_req_i.wstrb;
      n.rsp.wready = 1'b0;
    end
    if (s.aw_hold && s.w_hold && !s.rsp.bvalid) begin
      n.aw_hold    = 1'b0;
      n.w_hold     = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp  = `RESP_OKAY;
      if (s.aw_addr[`AXI_AW-1:2] == `CTRL_OFS >> 2) begin
        if (s.w_strb[0]) begin
          n.run_en           = s.w_data[`CTRL_RUN_BIT];
          n.register_pointer = s.w_data[`CTRL_RP_LSB +: 3];
        end
      end else if (s.aw_addr[`AXI_AW-1:2] != `STATUS_OFS >> 2) begin
        n.rsp.bresp = `RESP_SLVERR;
      end
    end
    if (s.rsp.bvalid && axi_req_i.bready) begin
      n.rsp.bvalid  = 1'b0;
      n.rsp.awready = 1'b1;
      n.rsp.wready  = 1'b1;
    end
    if (axi_req_i.arvalid && s.rsp.arready) begin
      n.rsp.arready = 1'b0;
      n.rsp.rvalid  = 1'b1;
      n.rsp.rresp   = `RESP_OKAY;
      n.rsp.rdata   = 32'h0000_0000;
      if (axi_req_i.araddr[`AXI_AW-1:2] == `CTRL_OFS >> 2) begin
        n.rsp.rdata[`CTRL_RUN_BIT]      = s.run_en;
        n.rsp.rdata[`CTRL_RP_LSB +: 3]  = s.register_pointer;
      end else if (axi_req_i.araddr[`AXI_AW-1:2] == `STATUS_OFS >> 2) begin
        n.rsp.rdata = status_word(s);
      end else begin
        n.rsp.rresp = `RESP_SLVERR;
      end
    end
    if (s.rsp.rvalid && axi_req_i.rready) begin
      n.rsp.rvalid  = 1'b0;
      n.rsp.arready = 1'b1;
    end
  end

  // ==========================================================================
  // state registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s                  <= '0;
      s.state            <= ST_RUN;
      s.pc               <= `PC_RST;
      s.sp               <= `SP_RST;
      s.register_pointer <= `RP_RST;
      s.rsp.awready      <= 1'b1;
      s.rsp.wready       <= 1'b1;
      s.rsp.arready      <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // data memory holds no reset: software-visible contents survive a reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_b_i && mem_we) begin
      dmem[mem_wa] <= mem_wd;
    end
  end

  assign imem_addr_o = s.pc;
  assign axi_rsp_o   = s.rsp;

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  logic [3:0]       m_val_q;
  logic [3:0]       arg_q;
  logic [6:0]       m_addr_q;
  logic [`PC_W-1:0] target_q;
  logic [6:0]       r_addr_q;
  logic [3:0]       r_val_q;
  logic             carry_q;
  always_ff @(posedge sys_clk_i) begin
    m_val_q  <= m_val;
    arg_q    <= ins.arg;
    m_addr_q <= m_addr;
    target_q <= target;
    r_addr_q <= r_addr;
    r_val_q  <= r_val;
    carry_q  <= s.carry_flag;
  end

  sequence seq_skip_then_idle;
    s.skip ##1 !s.skip;
  endsequence

  sequence seq_return_skip_word;
    exec && ins.op == OP_GROUP7 && ins.row == SUB_RETURN_AND_SKIP_OP && ins.col == 4'hE && ins.arg == 4'h0;
  endsequence

  AST_BRANCH_TARGET: assert property (
    exec && ins.op == OP_BRANCH |=> s.pc == target_q)
    else $error("branch did not load target");
  AST_ADD_IMM: assert property (
    exec && ins.op == OP_ADD_MI |=> dmem[m_addr_q] == m_val_q + arg_q)
    else $error("add immediate result wrong");
  AST_SKIP_EQUAL: assert property (
    exec && ins.op == OP_SKE && m_val == ins.arg |=> seq_skip_then_idle)
    else $error("equal compare did not skip once");
  AST_SKIP_GE: assert property (
    exec && ins.op == OP_SKIP_IF_GE_OP |=> s.skip == (m_val_q >= arg_q))
    else $error("greater-equal skip wrong");
  AST_SKIP_LT: assert property (
    exec && ins.op == OP_SKIP_IF_LT_OP |=> s.skip == (m_val_q < arg_q))
    else $error("less-than skip wrong");
  AST_BITS_CMP_CLEAR: assert property (
    exec && (ins.op == OP_SKT || ins.op == OP_SKF) |=> !s.compare_flag)
    else $error("bit test left compare flag set");
  AST_CALL_PUSH: assert property (
    exec && ins.op == OP_CALL |=> s.sp == $past(sp_dec) && s.stack[s.sp] == $past(pc_inc)
      && s.pc == target_q)
    else $error("call push wrong");
  AST_SKIPPED_QUIET: assert property (
    s.state == ST_RUN && s.run_en && s.skip |-> !mem_we ##1
      ($stable(s.carry_flag) && $stable(s.sp) && !s.skip))
    else $error("skipped word changed state");
  AST_HALT_ENTER: assert property (
    exec && ins.op == OP_GROUP7 && ins.row == SUB_HALT && ins.col == 4'hF
      |=> s.state == ST_HALT && s.pc == $past(pc_inc))
    else $error("halt did not suspend at the next word");
  AST_STOP_ENTER: assert property (
    exec && ins.op == OP_GROUP7 && ins.row == SUB_STOP && ins.col == 4'hF
      |=> s.state == ST_STOP && s.pc == $past(pc_inc))
    else $error("stop did not suspend at the next word");
  AST_SUB_IMM: assert property (
    exec && ins.op == OP_SUB_MI
      |=> dmem[m_addr_q] == m_val_q - arg_q && s.carry_flag == (m_val_q < arg_q))
    else $error("subtract immediate result wrong");
  AST_SKIP_NOT_EQUAL: assert property (
    exec && ins.op == OP_SKIP_IF_NOT_EQUAL_OP |=> s.skip == (m_val_q != arg_q))
    else $error("not-equal skip wrong");
  AST_BITS_CLEAR_SKIP: assert property (
    exec && ins.op == OP_SKF |=> s.skip == ((m_val_q & arg_q) == 4'h0))
    else $error("bits-clear skip wrong");
  AST_LOAD_COPY: assert property (
    exec && ins.op == OP_LOAD |=> dmem[r_addr_q] == m_val_q)
    else $error("load copy wrong");
  AST_STORE_COPY: assert property (
    exec && ins.op == OP_STORE |=> dmem[m_addr_q] == r_val_q)
    else $error("store copy wrong");
  AST_MOVE_IMM: assert property (
    exec && ins.op == OP_MOVI |=> dmem[m_addr_q] == arg_q)
    else $error("move immediate wrong");
  AST_RETURN_POP: assert property (
    exec && ins.op == OP_GROUP7 && ins.row == SUB_RET && ins.col == 4'hE && ins.arg == 4'h0
      |=> s.pc == $past(s.stack[s.sp]) && s.sp == $past(s.sp) + 2'h1 && !s.skip)
    else $error("return pop wrong");
  AST_RETURN_SKIP: assert property (
    seq_return_skip_word |=> s.pc == $past(s.stack[s.sp]) && s.skip ##1 $stable(s.sp))
    else $error("return-and-skip wrong");
  AST_ROTATE: assert property (
    exec && ins.op == OP_GROUP7 && ins.row == SUB_RET && ins.col == 4'h7
      |=> dmem[r_addr_q] == {carry_q, r_val_q[3:1]} && s.carry_flag == r_val_q[0])
    else $error("rotate through carry wrong");
  AST_UNDEFINED_QUIET: assert property (
    exec && ins.op inside {5'h0A, 5'h0D, 5'h0E, 5'h0F, 5'h1A} |-> !mem_we ##1
      ($stable(s.carry_flag) && $stable(s.sp) && !s.skip && s.pc == $past(pc_inc)))
    else $error("undefined opcode changed state");
endmodule : cpu_core

// [logic/cpu_cfg.svh]
`ifndef CPU_CFG_SVH
`define CPU_CFG_SVH
// ==========================================================================
// register map (byte addresses on the control bus)
`define AXI_AW          8
`define CTRL_OFS        8'h00
`define STATUS_OFS      8'h04
`define CTRL_RUN_BIT    0
`define CTRL_RP_LSB     4
`define STAT_PC_LSB     0
`define STAT_CY_BIT     16
`define STAT_CMP_BIT    17
`define STAT_SKIP_BIT   18
`define STAT_ST_LSB     20
`define STAT_SP_LSB     24
// ==========================================================================
// reset values and sizes
`define PC_W            11
`define SP_W            2
`define STACK_DEPTH     4
`define PC_RST          11'h000
`define SP_RST          2'h0
`define RP_RST          3'h0
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// [logic/cpu_pkg.sv]
`include "cpu_cfg.svh"
package cpu_pkg;
  typedef enum logic [4:0] {
    OP_ADD_RM  = 5'h00, OP_SUB_RM  = 5'h01, OP_ADD_WITH_CARRY_OP_RM = 5'h02, OP_SUB_WITH_BORROW_OP_RM = 5'h03,
    OP_AND_RM  = 5'h04, OP_XOR_RM  = 5'h05, OP_OR_RM   = 5'h06, OP_GROUP7  = 5'h07,
    OP_LOAD    = 5'h08, OP_SKE     = 5'h09, OP_SKIP_IF_NOT_EQUAL_OP    = 5'h0B, OP_BRANCH  = 5'h0C,
    OP_ADD_MI  = 5'h10, OP_SUB_MI  = 5'h11, OP_ADD_WITH_CARRY_OP_MI = 5'h12, OP_SUB_WITH_BORROW_OP_MI = 5'h13,
    OP_AND_MI  = 5'h14, OP_XOR_MI  = 5'h15, OP_OR_MI   = 5'h16, OP_STORE   = 5'h18,
    OP_SKIP_IF_GE_OP    = 5'h19, OP_SKIP_IF_LT_OP    = 5'h1B, OP_CALL    = 5'h1C, OP_MOVI    = 5'h1D,
    OP_SKT     = 5'h1E, OP_SKF     = 5'h1F
  } op_e;

  typedef enum logic [2:0] {
    SUB_RET = 3'h0, SUB_RETURN_AND_SKIP_OP = 3'h1, SUB_STOP = 3'h2, SUB_HALT = 3'h3, SUB_NOP = 3'h4
  } sub_e;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_HALT = 3'b010,
    ST_STOP = 3'b100
  } run_state_e;

  typedef struct packed {
    logic [4:0] op;
    logic [2:0] row;
    logic [3:0] col;
    logic [3:0] arg;
  } instr_s;

  typedef struct packed {
    logic [`AXI_AW-1:0] awaddr;
    logic               awvalid;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               wvalid;
    logic               bready;
    logic [`AXI_AW-1:0] araddr;
    logic               arvalid;
    logic               rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axi_rsp_s;

  typedef struct packed {
    run_state_e                         state;
    logic [`PC_W-1:0]                   pc;
    logic [`SP_W-1:0]                   sp;
    logic [`STACK_DEPTH-1:0][`PC_W-1:0] stack;
    logic                               carry_flag;
    logic                               compare_flag;
    logic                               skip;
    logic [3:0]                         rel_cond;
    logic [3:0]                         sync_a;
    logic [3:0]                         sync_b;
    logic [3:0]                         sync_c;
    logic [3:0]                         rel_level;
    logic                               run_en;
    logic [2:0]                         register_pointer;
    logic                               aw_hold;
    logic                               w_hold;
    logic [`AXI_AW-1:0]                 aw_addr;
    logic [31:0]                        w_data;
    logic [3:0]                         w_strb;
    axi_rsp_s                           rsp;
  } core_s;
endpackage : cpu_pkg

// [sim/prog_mem.sv]
module prog_mem (
  input  wire logic        sys_clk_i,
  input  wire logic [10:0] addr_i,
  input  wire logic        load_en_i,
  input  wire logic [10:0] load_addr_i,
  input  wire logic [15:0] load_data_i,
  output logic [15:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [2048];
  // ==========================================================
  // storage
  // unwritten words branch to the trap at 7F0 so strays are caught
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 16'h67F0;
    end
  end
  always @(posedge sys_clk_i) begin
    if (load_en_i) begin
      mem[load_addr_i] <= load_data_i;
    end
  end
  // async read, the core samples the word in the same cycle
  assign data_o = mem[addr_i];
endmodule : prog_mem

// [sim/tb.sv]
`include "cpu_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cpu_pkg::*;
  logic        clk;
  logic        rst_b;
  logic [3:0]  rel;
  logic [10:0] pc_addr;
  logic [15:0] word;
  logic        ld_en;
  logic [10:0] ld_addr;
  logic [15:0] ld_data;
  axi_req_s    req;
  axi_rsp_s    rsp;
  logic [15:0] prog [$];
  logic        cy;
  int          error_cnt;
  int          num_checks;

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  cpu_core u_cpu_core (.sys_clk_i(clk), .rst_b_i(rst_b), .imem_data_i(word), .release_i(rel),
                       .axi_req_i(req), .imem_addr_o(pc_addr), .axi_rsp_o(rsp));
  prog_mem u_prog_mem (.sys_clk_i(clk), .addr_i(pc_addr), .load_en_i(ld_en), .load_addr_i(ld_addr),
                       .load_data_i(ld_data), .data_o(word));

  // ==========================================================
  // report
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task tmo;
    error_cnt++;
    $display("wait limit reached at %0t", $time);
    stop_test();
  endtask : tmo

  // ==========================================================
  // register bus
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    req.awaddr <= a;
    req.awvalid <= 1'h1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'h1;
    req.bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready === 1'h1) req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready === 1'h1) req.wvalid <= 1'h0;
      if (rsp.bvalid === 1'h1) break;
    end
    if (n == 50) tmo();
    r = rsp.bresp;
    req.bready <= 1'h0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'h1;
    req.rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready === 1'h1) req.arvalid <= 1'h0;
      if (rsp.rvalid === 1'h1) break;
    end
    if (n == 50) tmo();
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'h0;
  endtask : axi_rd

  // ==========================================================
  // program building and running
  task op(input logic [4:0] o, input logic [2:0] rw, input logic [3:0] c, input logic [3:0] a);
    prog.push_back({o, rw, c, a});
  endtask : op
  // a wrong value falls into the branch to the trap at 7F0
  task expect_m(input logic [2:0] rw, input logic [3:0] c, input logic [3:0] v);
    op(5'h09, rw, c, v);
    op(5'h0C, 3'h7, 4'hF, 4'h0);
  endtask : expect_m
  task fin;
    prog.push_back({5'h0C, 11'(prog.size())});
  endtask : fin
  task wait_st(input logic [31:0] m, input logic [31:0] v, output logic [31:0] st);
    int n;
    logic [1:0] r;
    for (n = 0; n < 80; n++) begin
      axi_rd(`STATUS_OFS, st, r);
      if ((st & m) == v || st[10:0] == 11'h7F0) break;
    end
    if (n == 80) tmo();
  endtask : wait_st
  task start_prog(input logic [2:0] rp, output logic [10:0] e);
    logic [1:0] r;
    e = 11'(prog.size() - 1);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    cy = 1'h0;
    foreach (prog[i]) begin
      @(posedge clk);
      ld_en <= 1'h1;
      ld_addr <= 11'(i);
      ld_data <= prog[i];
    end
    @(posedge clk);
    ld_en <= 1'h0;
    prog.delete();
    axi_wr(`CTRL_OFS, {25'h0, rp, 4'h1}, r);
  endtask : start_prog
  task run_prog(input logic [2:0] rp, output logic [31:0] st);
    logic [10:0] e;
    start_prog(rp, e);
    wait_st(32'h7FF, {21'h0, e}, st);
    chk({21'h0, st[10:0]}, {21'h0, e});
  endtask : run_prog

  // ==========================================================
  // scenarios
  task t_bus;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(`STATUS_OFS, d, r);
    chk(d, 32'h0010_0000);
    axi_wr(`CTRL_OFS, 32'h50, r);
    axi_rd(`CTRL_OFS, d, r);
    chk(d, 32'h50);
    axi_wr(8'h08, 32'h1, r);
    chk({30'h0, r}, 32'h2);
    axi_rd(8'h0C, d, r);
    chk({r, d[29:0]}, 32'h8000_0000);
    axi_wr(`STATUS_OFS, 32'hFFFF, r);
    axi_rd(`STATUS_OFS, d, r);
    chk(d, 32'h0010_0000);
    $display("test bus done");
  endtask : t_bus
  task automatic t_alu;
    logic [4:0] ops [14] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16,
                             5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06};
    logic [3:0] a, b;
    logic [4:0] s;
    logic [31:0] st;
    logic c;
    c = 1'h0;
    for (int k = 0; k < 14; k++) begin
      a = 4'(k * 5 + 7);
      b = 4'(k * 3 + 9);
      case (ops[k][2:0])
        3'h0, 3'h2: s = {1'h0, a} + {1'h0, b} + 5'(ops[k][1] & c);
        3'h1, 3'h3: s = {1'h0, a} - {1'h0, b} - 5'(ops[k][1] & c);
        3'h4: s = {c, a & b};
        3'h5: s = {c, a ^ b};
        default: s = {c, a | b};
      endcase
      c = s[4];
      if (ops[k][4]) begin
        op(5'h1D, 3'h1, 4'(k), a);
        op(ops[k], 3'h1, 4'(k), b);
        expect_m(3'h1, 4'(k), s[3:0]);
      end else begin
        op(5'h1D, 3'h0, 4'(k), a);
        op(5'h1D, 3'h1, 4'(k), b);
        op(ops[k], 3'h1, 4'(k), 4'(k));
        expect_m(3'h0, 4'(k), s[3:0]);
      end
    end
    fin();
    run_prog(3'h0, st);
    chk({31'h0, st[16]}, {31'h0, c});
    $display("test alu done");
  endtask : t_alu
  task automatic t_skip;
    logic [4:0] ops [6] = '{5'h09, 5'h19, 5'h1B, 5'h0B, 5'h1E, 5'h1F};
    logic [3:0] imm [3] = '{4'h4, 4'h5, 4'h6};
    logic [3:0] msk [3] = '{4'h0, 4'h5, 4'h2};
    logic [3:0] a;
    logic [31:0] st;
    logic s;
    op(5'h1D, 3'h2, 4'h0, 4'h5);
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++) begin
        a = (i > 3) ? msk[j] : imm[j];
        case (ops[i])
          5'h09: s = (a == 4'h5);
          5'h19: s = (4'h5 >= a);
          5'h1B: s = (4'h5 < a);
          5'h0B: s = (a != 4'h5);
          5'h1E: s = ((4'h5 & a) == a);
          default: s = ((4'h5 & a) == 4'h0);
        endcase
        op(5'h1D, 3'h3, 4'h0, 4'h0);
        op(ops[i], 3'h2, 4'h0, a);
        op(5'h1D, 3'h3, 4'h0, 4'h1);
        expect_m(3'h3, 4'h0, {3'h0, !s});
      end
    end
    fin();
    run_prog(3'h0, st);
    chk({31'h0, st[17]}, 32'h0);
    $display("test skip done");
  endtask : t_skip
  task t_ldst;
    logic [31:0] st;
    op(5'h1D, 3'h3, 4'h4, 4'hA);
    op(5'h08, 3'h3, 4'h4, 4'h5);
    expect_m(3'h2, 4'h5, 4'hA);
    op(5'h1D, 3'h2, 4'h6, 4'h7);
    op(5'h18, 3'h4, 4'h1, 4'h6);
    expect_m(3'h4, 4'h1, 4'h7);
    op(5'h1D, 3'h0, 4'h0, 4'h1);
    op(5'h10, 3'h0, 4'h0, 4'h1);
    op(5'h07, 3'h0, 4'h7, 4'h6);
    expect_m(3'h2, 4'h6, 4'h3);
    op(5'h07, 3'h0, 4'h7, 4'h6);
    expect_m(3'h2, 4'h6, 4'h9);
    fin();
    run_prog(3'h2, st);
    chk({31'h0, st[16]}, 32'h1);
    $display("test load store done");
  endtask : t_ldst
  task t_call;
    logic [31:0] st;
    prog.push_back({5'h1C, 11'h010});
    prog.push_back({5'h1C, 11'h020});
    op(5'h0C, 3'h7, 4'hF, 4'h0);
    prog.push_back({5'h0C, 11'h1A3});
    while (prog.size() < 'h10) op(5'h0C, 3'h7, 4'hF, 4'h0);
    op(5'h07, 3'h0, 4'hE, 4'h0);
    while (prog.size() < 'h20) op(5'h0C, 3'h7, 4'hF, 4'h0);
    op(5'h07, 3'h1, 4'hE, 4'h0);
    while (prog.size() < 'h1A3) op(5'h0C, 3'h7, 4'hF, 4'h0);
    fin();
    run_prog(3'h0, st);
    chk({30'h0, st[25:24]}, 32'h0);
    $display("test call done");
  endtask : t_call
  task automatic t_halt;
    logic [4:0] bad [5] = '{5'h0A, 5'h0D, 5'h0E, 5'h0F, 5'h1A};
    logic [31:0] st, s2;
    logic [10:0] e;
    logic [1:0] r;
    op(5'h1D, 3'h0, 4'h0, 4'h3);
    foreach (bad[i]) op(bad[i], 3'h0, 4'h0, 4'h9);
    op(5'h07, 3'h5, 4'hF, 4'h0);
    op(5'h07, 3'h4, 4'hF, 4'h0);
    expect_m(3'h0, 4'h0, 4'h3);
    op(5'h07, 3'h3, 4'hF, 4'h2);
    op(5'h1D, 3'h3, 4'h1, 4'h6);
    op(5'h07, 3'h2, 4'hF, 4'h4);
    op(5'h1D, 3'h3, 4'h2, 4'h8);
    expect_m(3'h3, 4'h1, 4'h6);
    expect_m(3'h3, 4'h2, 4'h8);
    fin();
    start_prog(3'h0, e);
    wait_st(32'h0070_0000, 32'h0020_0000, st);
    chk({29'h0, st[22:20]}, 32'h2);
    // an unselected release line must not wake the core
    rel <= 4'h1;
    repeat (10) @(posedge clk);
    axi_rd(`STATUS_OFS, s2, r);
    chk(s2, st);
    rel <= 4'h2;
    wait_st(32'h0070_0000, 32'h0040_0000, st);
    chk({29'h0, st[22:20]}, 32'h4);
    rel <= 4'h4;
    wait_st(32'h7FF, {21'h0, e}, st);
    chk({21'h0, st[10:0]}, {21'h0, e});
    rel <= 4'h0;
    $display("test halt done");
  endtask : t_halt

  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst_b = 1'h0;
    rel = 4'h0;
    ld_en = 1'h0;
    ld_addr = 11'h0;
    ld_data = 16'h0;
    req = '0;
    cy = 1'h0;
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    t_bus();
    t_alu();
    t_skip();
    t_ldst();
    t_call();
    t_halt();
    stop_test();
  end
endmodule : tb
